// ---- splfc_assertions.sv ----
`timescale 1ns/1ns
`include "splfc_regs.svh"

module splfc_assertions
	import splfc_pkg::*;
(
	// bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	// flash side
	input wire logic eeprom_write_busy,
	input wire logic cpu_halt,
	input wire logic flash_req,
	input wire splfc_flash_cmd_s flash_cmd,
	input wire logic flash_done
);
	// ----------------
	// window age
	// ----------------
	logic [2:0] age_r;
	wire logic ctrl_wr;
	assign ctrl_wr = psel && penable && pwrite && pready && paddr == `SPLFC_OFF_CTRL;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// saturates so a stale window never looks fresh
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_r <= 3'h7;
		end else if (ctrl_wr) begin
			age_r <= 3'h0;
		end else if (age_r != 3'h7) begin
			age_r <= age_r + 3'h1;
		end
	end
	// ----------------
	// properties
	// ----------------
	chk_halt_req: assert property (cpu_halt |-> flash_req)
		else $error("halt without request");
	chk_halt_op: assert property ($rose(cpu_halt) |->
		flash_cmd.op inside {SPLFC_OP_PAGE_ERASE, SPLFC_OP_PAGE_WRITE})
		else $error("halt on wrong op");
	chk_halt_hold: assert property (cpu_halt && !flash_done |=> cpu_halt)
		else $error("halt dropped early");
	chk_done_release: assert property (flash_req && flash_done |=> !flash_req && !cpu_halt)
		else $error("no release after done");
	chk_eeprom_block: assert property (eeprom_write_busy && !flash_req |=> !cpu_halt)
		else $error("programming during eeprom write");
	chk_cmd_stable: assert property (flash_req && !flash_done |=> $stable(flash_cmd))
		else $error("command moved");
	chk_store_window: assert property ($rose(flash_req) && flash_cmd.op != SPLFC_OP_READ |->
		age_r <= 3'h4)
		else $error("store outside window");
	chk_quiet_ops: assert property (flash_req &&
		flash_cmd.op inside {SPLFC_OP_BUF_LOAD, SPLFC_OP_READ} |-> !cpu_halt)
		else $error("halt on quiet op");
	cover property ($rose(cpu_halt));
	cover property (flash_req && flash_done && flash_cmd.op == SPLFC_OP_READ);
	cover property (eeprom_write_busy && ctrl_wr);
endmodule : splfc_assertions

bind splfc_top splfc_assertions u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pready,
	.eeprom_write_busy, .cpu_halt, .flash_req, .flash_cmd, .flash_done);

// ---- splfc_bench.sv ----
`timescale 1ns/1ns
`include "splfc_regs.svh"

module splfc_bench
	import splfc_pkg::*;
;
	// ----------------
	// signals
	// ----------------
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, cpu_halt, irq_disable, flash_req, flash_done, e;
	logic exec_in_boot = 1'h0, eeprom_write_busy = 1'h0, chip_erase = 1'h0, req_d = 1'h0;
	logic halt_d = 1'h0;
	logic [7:0] fuse_low = 8'h00, flash_rdata;
	logic [2:0] fuse_high = 3'h7;
	logic [1:0] general_lock = 2'h3;
	logic [3:0] boot_lock_init = 4'hF, dly = 4'h0;
	splfc_flash_cmd_s flash_cmd;
	int n_fail = 0, n_checks = 0, cyc = 0, n_req = 0, lk, d, z, p, o, tb, n0;
	int n_halt = 0, h0;
	logic [4:0] pats [4] = '{5'h01, 5'h03, 5'h05, 5'h11};
	int ptrs [4] = '{0, 1, 3, 2};

	splfc_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .exec_in_boot, .cpu_halt, .irq_disable, .eeprom_write_busy, .fuse_low,
		.fuse_high, .general_lock, .boot_lock_init, .chip_erase, .flash_req, .flash_cmd,
		.flash_done, .flash_rdata);
	splfc_flash_model u_flash (.pclk, .presetn, .flash_req, .flash_cmd, .dly, .flash_done,
		.flash_rdata);

	always #25 pclk = ~pclk;

	// ceiling far above the thousand or so cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		n_req += flash_req === 1'h1 && req_d !== 1'h1;
		req_d = flash_req;
		n_halt += cpu_halt === 1'h1 && halt_d !== 1'h1;
		halt_d = cpu_halt;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end

	// ----------------
	// tasks
	// ----------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb

	// k idle cycles push the instruction later into the window
	task automatic cmd(input logic [4:0] pat, input logic [15:0] zp, input int k,
		input logic [1:0] ins);
		apb(1'h1, `SPLFC_OFF_ZPTR, {16'h0, zp});
		apb(1'h1, `SPLFC_OFF_CTRL, {27'h0, pat});
		repeat (k) @(posedge pclk);
		apb(1'h1, `SPLFC_OFF_INSTR, {30'h0, ins});
		q = 32'h1;
		for (int i = 0; i < 40 && q[0] !== 1'h0; i++) begin
			apb(1'h0, `SPLFC_OFF_STATUS, 32'h0);
		end
	endtask : cmd

	function automatic logic [7:0] spec(input int zp);
		case (zp)
			0: return fuse_low;
			1: return {2'h3, lk[3:0], general_lock};
			3: return {5'h1F, fuse_high};
			default: return 8'hFF;
		endcase
	endfunction : spec

	// ----------------
	// tests
	// ----------------
	initial begin
		q = $urandom(32'h9165);
		n0 = $urandom;
		{fuse_low, fuse_high, general_lock, boot_lock_init} <= n0[16:0];
		lk = n0[3:0];
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		apb(1'h0, `SPLFC_OFF_STATUS, 32'h0);
		chk("status", q, {24'h0, boot_lock_init, 4'h0});
		apb(1'h0, `SPLFC_OFF_CTRL, 32'h0);
		chk("ctrl", q, 32'h0);
		apb(1'h0, 8'h18, 32'h0);
		chk("unmapped", {q[30:0], e}, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			z = i < 4 ? ptrs[i] : 1;
			cmd(5'h09, z[15:0], i < 4 ? 0 : i - 2, 2'h2);
			apb(1'h0, `SPLFC_OFF_RESULT, 32'h0);
			p = i == 5 ? 8'h01 ^ 8'hA5 : spec(z);
			chk("special", q, {23'h0, 1'h1, p[7:0]});
		end
		$display("test special reads done");
		for (int r = 0; r < 3; r++) begin
			chip_erase <= 1'h1;
			@(posedge pclk);
			chip_erase <= 1'h0;
			lk = 15;
			for (int j = 0; r > 0 && j < 3; j++) begin
				d = $urandom;
				apb(1'h1, `SPLFC_OFF_DATA, {24'h0, d[7:0]});
				cmd(5'h09, 16'h0, j == 0 ? 2 : 0, 2'h1);
				lk = j > 0 ? lk & d[5:2] : lk;
			end
			cmd(5'h09, 16'h1, 0, 2'h2);
			apb(1'h0, `SPLFC_OFF_RESULT, 32'h0);
			chk("lock byte", q, {23'h0, 1'h1, spec(1)});
			for (int t = 0; t < 12; t++) begin
				tb = t % 2;
				o = t / 2;
				z = tb ? 32'h3FFE : 0;
				exec_in_boot <= o == 5;
				dly <= $urandom % 6;
				n0 = n_req;
				h0 = n_halt;
				if (o < 4) begin
					cmd(pats[o], z[15:0], 0, 2'h1);
					p = o == 0 || o < 3 && (tb ? lk[2] : lk[0]);
					chk("req", n_req - n0, p);
					chk("halt", n_halt - h0, p && o > 0);
				end else begin
					cmd(5'h00, z[15:0], 0, 2'h2);
					apb(1'h0, `SPLFC_OFF_RESULT, 32'h0);
					p = o == 5 ? !tb && !lk[1] : tb && !lk[3];
					chk("load", q, {23'h0, 1'h1, p ? 8'hFF : z[7:0] ^ 8'hA5});
					chk("irq", irq_disable, o == 5 && !lk[3]);
				end
			end
		end
		$display("test lock protection done");
		for (int i = 0; i < 9; i++) begin
			p = $urandom % 32;
			p = i == 8 ? 9 : p inside {1, 3, 5, 9, 17} ? 31 : p;
			eeprom_write_busy <= i == 8;
			apb(1'h1, `SPLFC_OFF_CTRL, p);
			apb(1'h0, `SPLFC_OFF_CTRL, 32'h0);
			chk("ctrl", q, 32'h0);
		end
		eeprom_write_busy <= 1'h0;
		// window opened while idle, then an eeprom write starts inside it
		for (int i = 0; i < 2; i++) begin
			n0 = n_req;
			apb(1'h1, `SPLFC_OFF_CTRL, i ? 32'h9 : 32'h1);
			eeprom_write_busy <= 1'h1;
			apb(1'h1, `SPLFC_OFF_INSTR, i ? 32'h2 : 32'h1);
			eeprom_write_busy <= 1'h0;
			apb(1'h0, `SPLFC_OFF_RESULT, 32'h0);
			chk("eeprom", i ? q : n_req - n0, i ? 32'h1FF : 32'h0);
		end
		$display("test refused patterns done");
		conclude();
	end
endmodule : splfc_bench

// ---- splfc_flash_model.sv ----
`timescale 1ns/1ns

module splfc_flash_model
	import splfc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// array port
	input wire logic flash_req,
	input wire splfc_flash_cmd_s flash_cmd,
	input wire logic [3:0] dly,
	output logic flash_done,
	output logic [7:0] flash_rdata
);
	logic [3:0] cnt_r;
	// read data toggles outside the done cycle so a late sample is caught
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 4'h0;
			flash_done <= 1'h0;
			flash_rdata <= 8'h00;
		end else if (flash_req && !flash_done && cnt_r >= dly) begin
			cnt_r <= 4'h0;
			flash_done <= 1'h1;
			flash_rdata <= flash_cmd.addr[7:0] ^ 8'hA5;
		end else begin
			cnt_r <= (flash_req && !flash_done) ? cnt_r + 4'h1 : 4'h0;
			flash_done <= 1'h0;
			flash_rdata <= ~flash_rdata;
		end
	end
endmodule : splfc_flash_model

// ---- splfc_lock_guard.sv ----
`timescale 1ns/1ns
`include "splfc_regs.svh"

module splfc_lock_guard
	import splfc_pkg::*;
(
	// lock and fuse state
	input wire splfc_boot_lock_s boot_lock,
	input wire logic [1:0] boot_size,
	// access under test
	input wire logic [15:0] zaddr,
	input wire logic exec_in_boot,
	// verdicts
	output logic store_ok,
	output logic load_ok,
	output logic target_boot
);

	// ----------------------------------------------------------------
	// section boundary
	// ----------------------------------------------------------------
	function automatic logic [12:0] splfc_boot_start(input logic [1:0] sz);
		case (sz)
			2'b11: splfc_boot_start = `SPLFC_BOOT_START_11;
			2'b10: splfc_boot_start = `SPLFC_BOOT_START_10;
			2'b01: splfc_boot_start = `SPLFC_BOOT_START_01;
			default: splfc_boot_start = `SPLFC_BOOT_START_00;
		endcase
	endfunction : splfc_boot_start

	wire logic [12:0] word_addr = zaddr[13:1];
	assign target_boot = (word_addr >= splfc_boot_start(boot_size));

	// ----------------------------------------------------------------
	// protection decode, programmed bit is zero
	// ----------------------------------------------------------------
	wire logic app_store_ok = boot_lock.app_lock_low;
	wire logic boot_store_ok = boot_lock.boot_lock_low;
	wire logic app_read_ok = boot_lock.app_lock_high | ~exec_in_boot;
	wire logic boot_read_ok = boot_lock.boot_lock_high | exec_in_boot;

	assign store_ok = target_boot ? boot_store_ok : app_store_ok;
	assign load_ok = target_boot ? boot_read_ok : app_read_ok;

endmodule : splfc_lock_guard

// ---- splfc_pkg.sv ----
package splfc_pkg;

	// ----------------------------------------------------------------
	// sequencer states and flash operations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SPLFC_ST_IDLE = 2'b00,
		SPLFC_ST_PROG = 2'b01,
		SPLFC_ST_READ = 2'b10
	} splfc_state_e;

	typedef enum logic [2:0] {
		SPLFC_OP_NONE = 3'b000,
		SPLFC_OP_BUF_LOAD = 3'b001,
		SPLFC_OP_PAGE_ERASE = 3'b010,
		SPLFC_OP_PAGE_WRITE = 3'b011,
		SPLFC_OP_READ = 3'b100
	} splfc_op_e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		splfc_op_e op;
		logic [15:0] addr;
		logic [15:0] wdata;
	} splfc_flash_cmd_s;

	// order matches data bits 5..2 of a lock write
	typedef struct packed {
		logic boot_lock_high;
		logic boot_lock_low;
		logic app_lock_high;
		logic app_lock_low;
	} splfc_boot_lock_s;

	// order matches the low five control bits
	typedef struct packed {
		logic app_section_read_enable;
		logic lock_bit_set_ctrl;
		logic page_write_ctrl;
		logic page_erase_ctrl;
		logic store_enable_ctrl;
	} splfc_ctrl_s;

endpackage : splfc_pkg

// ---- splfc_regs.svh ----
`ifndef SPLFC_REGS_SVH
`define SPLFC_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SPLFC_OFF_CTRL 8'h00
`define SPLFC_OFF_DATA 8'h04
`define SPLFC_OFF_ZPTR 8'h08
`define SPLFC_OFF_INSTR 8'h0C
`define SPLFC_OFF_RESULT 8'h10
`define SPLFC_OFF_STATUS 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPLFC_INSTR_STORE 0
`define SPLFC_INSTR_LOAD 1
`define SPLFC_DATA_LOCK_HI 5
`define SPLFC_DATA_LOCK_LO 2

// ----------------------------------------------------------------
// control patterns in the low five bits
// ----------------------------------------------------------------
`define SPLFC_PAT_APP_READ 5'h11
`define SPLFC_PAT_LOCK_SET 5'h09
`define SPLFC_PAT_PAGE_WRITE 5'h05
`define SPLFC_PAT_PAGE_ERASE 5'h03
`define SPLFC_PAT_BUF_LOAD 5'h01

// ----------------------------------------------------------------
// command windows in clock cycles
// ----------------------------------------------------------------
`define SPLFC_STORE_WIN 3'h4
`define SPLFC_LOAD_WIN 3'h5
`define SPLFC_AGE_MAX 3'h7

// ----------------------------------------------------------------
// special read pointers and values
// ----------------------------------------------------------------
`define SPLFC_PTR_FUSE_LOW 16'h0000
`define SPLFC_PTR_LOCK 16'h0001
`define SPLFC_PTR_FUSE_HIGH 16'h0003
`define SPLFC_UNDEF_BYTE 8'hFF
`define SPLFC_UNPROG_LOCKS 4'hF

// ----------------------------------------------------------------
// first boot word per boot size selection
// ----------------------------------------------------------------
`define SPLFC_BOOT_START_11 13'h1F80
`define SPLFC_BOOT_START_10 13'h1F00
`define SPLFC_BOOT_START_01 13'h1E00
`define SPLFC_BOOT_START_00 13'h1C00

`endif

// ---- splfc_top.sv ----
`timescale 1ns/1ns
`include "splfc_regs.svh"

module splfc_top
	import splfc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu side
	input wire logic exec_in_boot,
	output logic cpu_halt,
	output logic irq_disable,
	// eeprom status, same clock
	input wire logic eeprom_write_busy,
	// nonvolatile straps, static, and the chip erase strobe, same clock
	input wire logic [7:0] fuse_low,
	input wire logic [2:0] fuse_high,
	input wire logic [1:0] general_lock,
	input wire logic [3:0] boot_lock_init,
	input wire logic chip_erase,
	// flash array port
	output logic flash_req,
	output splfc_flash_cmd_s flash_cmd,
	input wire logic flash_done,
	input wire logic [7:0] flash_rdata
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	splfc_state_e state_r, state_nxt;
	splfc_ctrl_s ctrl_r, ctrl_nxt;
	splfc_boot_lock_s lock_r, lock_nxt;
	splfc_flash_cmd_s cmd_r, cmd_nxt;
	logic [2:0] age_r, age_nxt;
	logic [15:0] data_r;
	logic [15:0] zptr_r;
	logic [7:0] result_r, result_nxt;
	logic rvalid_r, rvalid_nxt;
	logic req_r, req_nxt;
	logic halt_r, halt_nxt;
	logic [7:0] fuse_low_r;
	logic [2:0] fuse_high_r;
	logic [1:0] glock_r;
	logic loaded_r;
	logic [31:0] prdata_r;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire logic setup = psel & ~penable;
	wire logic access = psel & penable;
	wire logic wr_acc = access & pwrite;
	wire logic hit_ctrl = (paddr == `SPLFC_OFF_CTRL);
	wire logic hit_data = (paddr == `SPLFC_OFF_DATA);
	wire logic hit_zptr = (paddr == `SPLFC_OFF_ZPTR);
	wire logic hit_instr = (paddr == `SPLFC_OFF_INSTR);
	wire logic hit_result = (paddr == `SPLFC_OFF_RESULT);
	wire logic hit_status = (paddr == `SPLFC_OFF_STATUS);
	wire logic mapped = hit_ctrl | hit_data | hit_zptr | hit_instr | hit_result | hit_status;

	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// ----------------------------------------------------------------
	// control pattern check
	// ----------------------------------------------------------------
	function automatic logic splfc_pattern_ok(input logic [4:0] pat);
		splfc_pattern_ok = (pat == `SPLFC_PAT_APP_READ) | (pat == `SPLFC_PAT_LOCK_SET) |
			(pat == `SPLFC_PAT_PAGE_WRITE) | (pat == `SPLFC_PAT_PAGE_ERASE) |
			(pat == `SPLFC_PAT_BUF_LOAD);
	endfunction : splfc_pattern_ok

	wire logic idle = (state_r == SPLFC_ST_IDLE);
	// eeprom writes lock the control register, so no window can open
	wire logic ctrl_wr = wr_acc & hit_ctrl & idle & ~eeprom_write_busy &
		splfc_pattern_ok(pwdata[4:0]);
	wire logic ins_store = wr_acc & hit_instr & idle & pwdata[`SPLFC_INSTR_STORE];
	wire logic ins_load = wr_acc & hit_instr & idle & ~pwdata[`SPLFC_INSTR_STORE] &
		pwdata[`SPLFC_INSTR_LOAD];

	// ----------------------------------------------------------------
	// command windows
	// ----------------------------------------------------------------
	wire logic win_open = idle & ctrl_r.store_enable_ctrl;
	wire logic store_in_win = win_open & (age_r < `SPLFC_STORE_WIN);
	wire logic load_in_win = win_open & ctrl_r.lock_bit_set_ctrl &
		(age_r < `SPLFC_LOAD_WIN);
	wire logic [2:0] win_last = ctrl_r.lock_bit_set_ctrl ?
		(`SPLFC_LOAD_WIN - 3'h1) : (`SPLFC_STORE_WIN - 3'h1);
	wire logic expire = win_open & (age_r == win_last);

	// ----------------------------------------------------------------
	// lock protection
	// ----------------------------------------------------------------
	logic store_ok;
	logic load_ok;

	splfc_lock_guard u_guard (
		.boot_lock(lock_r),
		.boot_size(fuse_high_r[2:1]),
		.zaddr(zptr_r),
		.exec_in_boot(exec_in_boot),
		.store_ok(store_ok),
		.load_ok(load_ok),
		.target_boot()
	);

	// ----------------------------------------------------------------
	// special read mux
	// ----------------------------------------------------------------
	// unassigned positions return ones
	wire logic [7:0] lock_byte = {2'b11, lock_r, glock_r};
	wire logic [7:0] fuse_high_byte = {5'b11111, fuse_high_r};
	wire logic [7:0] special_byte =
		(zptr_r == `SPLFC_PTR_LOCK) ? lock_byte :
		(zptr_r == `SPLFC_PTR_FUSE_LOW) ? fuse_low_r :
		(zptr_r == `SPLFC_PTR_FUSE_HIGH) ? fuse_high_byte :
		`SPLFC_UNDEF_BYTE;

	// ----------------------------------------------------------------
	// sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		lock_nxt = lock_r;
		cmd_nxt = cmd_r;
		req_nxt = req_r;
		halt_nxt = halt_r;
		result_nxt = result_r;
		rvalid_nxt = rvalid_r;
		age_nxt = (win_open && age_r != `SPLFC_AGE_MAX) ? age_r + 3'h1 : age_r;
		case (state_r)
			SPLFC_ST_IDLE: begin
				if (ctrl_wr) begin
					ctrl_nxt = pwdata[4:0];
					age_nxt = 3'h0;
				end else if (ins_store && store_in_win) begin
					ctrl_nxt = '0;
					if (eeprom_write_busy) begin
						ctrl_nxt = '0;
					end else if (ctrl_r.lock_bit_set_ctrl) begin
						// general locks live outside this field entirely
						lock_nxt = lock_r &
							data_r[`SPLFC_DATA_LOCK_HI:`SPLFC_DATA_LOCK_LO];
					end else if (ctrl_r.page_erase_ctrl || ctrl_r.page_write_ctrl) begin
						if (store_ok) begin
							ctrl_nxt = ctrl_r;
							state_nxt = SPLFC_ST_PROG;
							req_nxt = 1'b1;
							halt_nxt = 1'b1;
							cmd_nxt.op = ctrl_r.page_erase_ctrl ? SPLFC_OP_PAGE_ERASE :
								SPLFC_OP_PAGE_WRITE;
							cmd_nxt.addr = zptr_r;
							cmd_nxt.wdata = data_r;
						end
					end else if (ctrl_r.app_section_read_enable) begin
						ctrl_nxt = '0;
					end else begin
						ctrl_nxt = ctrl_r;
						state_nxt = SPLFC_ST_PROG;
						req_nxt = 1'b1;
						cmd_nxt.op = SPLFC_OP_BUF_LOAD;
						cmd_nxt.addr = zptr_r;
						cmd_nxt.wdata = data_r;
					end
				end else if (ins_load && load_in_win) begin
					ctrl_nxt = '0;
					rvalid_nxt = 1'b1;
					result_nxt = eeprom_write_busy ? `SPLFC_UNDEF_BYTE :
						special_byte;
				end else if (ins_load) begin
					rvalid_nxt = 1'b0;
					state_nxt = SPLFC_ST_READ;
					req_nxt = 1'b1;
					cmd_nxt.op = SPLFC_OP_READ;
					cmd_nxt.addr = zptr_r;
					cmd_nxt.wdata = '0;
				end else if (expire) begin
					ctrl_nxt = '0;
				end
			end
			SPLFC_ST_PROG: begin
				// enable stays high until the array reports completion
				if (flash_done) begin
					state_nxt = SPLFC_ST_IDLE;
					ctrl_nxt = '0;
					req_nxt = 1'b0;
					halt_nxt = 1'b0;
					cmd_nxt.op = SPLFC_OP_NONE;
				end
			end
			SPLFC_ST_READ: begin
				if (flash_done) begin
					state_nxt = SPLFC_ST_IDLE;
					req_nxt = 1'b0;
					rvalid_nxt = 1'b1;
					result_nxt = load_ok ? flash_rdata : `SPLFC_UNDEF_BYTE;
					cmd_nxt.op = SPLFC_OP_NONE;
				end
			end
			default: begin
				state_nxt = SPLFC_ST_IDLE;
				ctrl_nxt = '0;
				req_nxt = 1'b0;
				halt_nxt = 1'b0;
			end
		endcase
		if (chip_erase) begin
			lock_nxt = `SPLFC_UNPROG_LOCKS;
		end else if (!loaded_r) begin
			lock_nxt = boot_lock_init;
		end
	end

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	// busy flag has no function here and reads zero
	wire logic [31:0] rd_ctrl = {24'h000000, 3'b000, ctrl_r};
	wire logic [31:0] rd_status = {24'h000000, lock_r, eeprom_write_busy, irq_disable,
		halt_r, ~idle};
	wire logic [31:0] rd_mux =
		hit_ctrl ? rd_ctrl :
		hit_data ? {16'h0000, data_r} :
		hit_zptr ? {16'h0000, zptr_r} :
		hit_result ? {23'h000000, rvalid_r, result_r} :
		hit_status ? rd_status :
		32'h00000000;

	// ----------------------------------------------------------------
	// flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= SPLFC_ST_IDLE;
			ctrl_r <= '0;
			lock_r <= `SPLFC_UNPROG_LOCKS;
			cmd_r <= '0;
			age_r <= 3'h0;
			req_r <= 1'b0;
			halt_r <= 1'b0;
			result_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			lock_r <= lock_nxt;
			cmd_r <= cmd_nxt;
			age_r <= age_nxt;
			req_r <= req_nxt;
			halt_r <= halt_nxt;
			result_r <= result_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// strap capture
	// ----------------------------------------------------------------
	// straps caught on the first edge after release, never at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_r <= 1'b0;
			fuse_low_r <= 8'hFF;
			fuse_high_r <= 3'h7;
			glock_r <= 2'h3;
		end else if (!loaded_r) begin
			loaded_r <= 1'b1;
			fuse_low_r <= fuse_low;
			fuse_high_r <= fuse_high;
			glock_r <= general_lock;
		end
	end

	// ----------------------------------------------------------------
	// data and pointer registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_r <= 16'h0000;
			zptr_r <= 16'h0000;
		end else if (wr_acc && hit_data) begin
			data_r <= pwdata[15:0];
		end else if (wr_acc && hit_zptr) begin
			zptr_r <= pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// read capture
	// ----------------------------------------------------------------
	// read data captured in the setup cycle, so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_r;
	assign cpu_halt = halt_r;
	assign flash_req = req_r;
	assign flash_cmd = cmd_r;
	assign irq_disable = exec_in_boot & ~lock_r.boot_lock_high;

endmodule : splfc_top
